// ### pkg/csd_pkg.sv
package csd_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [5:0] CSD_OFF_INSTR = 6'h00;
	localparam logic [5:0] CSD_OFF_WORK = 6'h04;
	localparam logic [5:0] CSD_OFF_BANK = 6'h08;
	localparam logic [5:0] CSD_OFF_DATA = 6'h0C;
	localparam logic [5:0] CSD_OFF_INDEX = 6'h10;
	localparam logic [5:0] CSD_OFF_FLAGS = 6'h14;
	localparam logic [5:0] CSD_OFF_CTRL = 6'h18;
	localparam logic [5:0] CSD_OFF_STATUS = 6'h1C;
	localparam logic [5:0] CSD_OFF_ADDR = 6'h20;

	////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int CSD_FLAG_CARRY = 0;
	localparam int CSD_FLAG_DIGIT = 1;
	localparam int CSD_CTRL_GO = 0;
	localparam int CSD_CTRL_TWO_WORD = 1;
	localparam int CSD_CTRL_EXT = 2;
	localparam int CSD_OP_BANK_BIT = 8;

	////////////////////////////////////////////////////////////////////////
	// Opcodes and addressing constants.
	localparam logic [6:0] CSD_OPC_GREATER = 7'h32;
	localparam logic [6:0] CSD_OPC_LESS = 7'h30;
	localparam logic [15:0] CSD_OPC_DECIMAL = 16'h0007;
	localparam logic [7:0] CSD_INDEXED_MAX = 8'h5F;
	localparam logic [7:0] CSD_ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] CSD_ACCESS_HIGH_BANK = 4'hF;
	localparam logic [4:0] CSD_BCD_LIMIT = 5'h09;
	localparam logic [4:0] CSD_BCD_FIX = 5'h06;

	////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [15:0] CSD_RST_INSTR = 16'h0000;
	localparam logic [7:0] CSD_RST_BYTE = 8'h00;
	localparam logic [3:0] CSD_RST_BANK = 4'h0;
	localparam logic [11:0] CSD_RST_ADDR = 12'h000;

	////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [1:0] {
		CSD_OP_NONE = 2'b00,
		CSD_OP_GREATER = 2'b01,
		CSD_OP_LESS = 2'b11,
		CSD_OP_DECIMAL = 2'b10
	} csd_op_t;

	typedef enum logic [1:0] {
		CSD_ST_IDLE = 2'b00,
		CSD_ST_EXEC = 2'b01,
		CSD_ST_FLUSH = 2'b11
	} csd_state_t;

	typedef enum logic [1:0] {
		CSD_Q1 = 2'b00,
		CSD_Q2 = 2'b01,
		CSD_Q3 = 2'b11,
		CSD_Q4 = 2'b10
	} csd_phase_t;

	typedef struct packed {
		logic [5:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} csd_req_t;

	typedef struct packed {
		logic [1:0] cycles;
		logic unknown_op;
		logic indexed;
		logic skip;
		logic busy;
	} csd_status_t;

endpackage : csd_pkg

// ### rtl/csd_core.sv
`timescale 1ns/1ps
`default_nettype none

module csd_core (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Avalon-MM slave.
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Fetch pipeline control.
	output logic cancel_fetch
);
	import csd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	csd_req_t req;
	logic [31:0] readdata_q;
	logic waitrequest_q;
	logic bus_take;
	logic [15:0] instr_q;
	logic [7:0] working_register_q;
	logic [3:0] bank_select_register_q;
	logic [7:0] data_q;
	logic [11:0] index_q;
	logic carry_q;
	logic digit_carry_flag_q;
	logic two_word_q;
	logic ext_q;
	csd_state_t state_q;
	csd_phase_t phase_q;
	csd_op_t op_q;
	csd_status_t status_q;
	logic [11:0] addr_q;
	logic [7:0] operand_q;
	logic skip_q;
	logic [1:0] flush_left_q;
	logic cancel_q;
	logic [8:0] diff;
	logic [4:0] low_sum;
	logic [4:0] high_base;
	logic [4:0] high_sum;
	logic [7:0] adjusted;
	logic adjust_carry;
	logic go;
	logic q4_end;

	assign req = '{address: avs_address, read: avs_read,
		write: avs_write, writedata: avs_writedata};
	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitrequest_q;
	assign cancel_fetch = cancel_q;

	////////////////////////////////////////////////////////////////////////
	// Each access is answered on the second edge; the extra cycle keeps
	// read data registered and lets waitrequest come from a flip-flop.
	assign bus_take = (req.read | req.write) & ~waitrequest_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			waitrequest_q <= 1'b1;
		end else if ((req.read | req.write) & waitrequest_q) begin
			waitrequest_q <= 1'b0;
		end else begin
			waitrequest_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			readdata_q <= 32'h0000_0000;
		end else if (req.read & waitrequest_q) begin
			unique case (req.address)
				CSD_OFF_INSTR: readdata_q <= {16'h0000, instr_q};
				CSD_OFF_WORK: readdata_q <= {24'h000000, working_register_q};
				CSD_OFF_BANK: readdata_q <= {28'h0000000, bank_select_register_q};
				CSD_OFF_DATA: readdata_q <= {24'h000000, data_q};
				CSD_OFF_INDEX: readdata_q <= {20'h00000, index_q};
				CSD_OFF_FLAGS: begin
					readdata_q <= 32'h0000_0000;
					readdata_q[CSD_FLAG_CARRY] <= carry_q;
					readdata_q[CSD_FLAG_DIGIT] <= digit_carry_flag_q;
				end
				CSD_OFF_CTRL: begin
					// The go bit is a strobe and always reads back as zero.
					readdata_q <= 32'h0000_0000;
					readdata_q[CSD_CTRL_TWO_WORD] <= two_word_q;
					readdata_q[CSD_CTRL_EXT] <= ext_q;
				end
				CSD_OFF_STATUS: readdata_q <= {26'h0000000, status_q};
				CSD_OFF_ADDR: readdata_q <= {20'h00000, addr_q};
				default: readdata_q <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software-owned registers. Writes land while idle only, so the
	// operands of a running instruction cannot shift under it.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			instr_q <= CSD_RST_INSTR;
			bank_select_register_q <= CSD_RST_BANK;
			data_q <= CSD_RST_BYTE;
			index_q <= CSD_RST_ADDR;
			two_word_q <= 1'b0;
			ext_q <= 1'b0;
		end else if (bus_take & req.write & (state_q == CSD_ST_IDLE)) begin
			unique case (req.address)
				CSD_OFF_INSTR: instr_q <= req.writedata[15:0];
				CSD_OFF_BANK: bank_select_register_q <= req.writedata[3:0];
				CSD_OFF_DATA: data_q <= req.writedata[7:0];
				CSD_OFF_INDEX: index_q <= req.writedata[11:0];
				CSD_OFF_CTRL: begin
					two_word_q <= req.writedata[CSD_CTRL_TWO_WORD];
					ext_q <= req.writedata[CSD_CTRL_EXT];
				end
				default: ;
			endcase
		end
	end

	assign go = bus_take & req.write & (req.address == CSD_OFF_CTRL) &
		req.writedata[CSD_CTRL_GO] & (state_q == CSD_ST_IDLE);
	assign q4_end = (phase_q == CSD_Q4);

	////////////////////////////////////////////////////////////////////////
	// Sequencer: one sys_clk per quarter, four quarters per cycle.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= CSD_ST_IDLE;
			phase_q <= CSD_Q1;
			flush_left_q <= 2'h0;
			cancel_q <= 1'b0;
		end else begin
			unique case (state_q)
				CSD_ST_IDLE: begin
					phase_q <= CSD_Q1;
					if (go) begin
						state_q <= CSD_ST_EXEC;
					end
				end
				CSD_ST_EXEC: begin
					phase_q <= csd_phase_t'({phase_q[0], ~phase_q[1]});
					if (q4_end) begin
						if (skip_q) begin
							state_q <= CSD_ST_FLUSH;
							cancel_q <= 1'b1;
							flush_left_q <= two_word_q ? 2'h2 : 2'h1;
						end else begin
							state_q <= CSD_ST_IDLE;
						end
					end
				end
				CSD_ST_FLUSH: begin
					// Idle quarters stand in for the discarded words.
					phase_q <= csd_phase_t'({phase_q[0], ~phase_q[1]});
					if (q4_end) begin
						flush_left_q <= flush_left_q - 2'h1;
						if (flush_left_q == 2'h1) begin
							state_q <= CSD_ST_IDLE;
							cancel_q <= 1'b0;
						end
					end
				end
				default: state_q <= CSD_ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Datapath: subtraction and decimal correction.
	// The high nibble takes the digit carry flag itself, not the carry out of
	// the low nibble, so a wrap in the low nibble never ripples upward.
	assign diff = {1'b0, operand_q} - {1'b0, working_register_q};
	always_comb begin
		low_sum = {1'b0, working_register_q[3:0]};
		if ((low_sum > CSD_BCD_LIMIT) | digit_carry_flag_q) begin
			low_sum = low_sum + CSD_BCD_FIX;
		end
		high_base = {1'b0, working_register_q[7:4]} + {4'h0, digit_carry_flag_q};
		high_sum = high_base;
		if ((high_base > CSD_BCD_LIMIT) | carry_q) begin
			high_sum = high_base + CSD_BCD_FIX;
		end
		adjusted = {high_sum[3:0], low_sum[3:0]};
		adjust_carry = high_sum[4] | carry_q;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			op_q <= CSD_OP_NONE;
			addr_q <= CSD_RST_ADDR;
			operand_q <= CSD_RST_BYTE;
			skip_q <= 1'b0;
			status_q <= '0;
		end else begin
			status_q.busy <= (state_q != CSD_ST_IDLE) | go;
			if (go) begin
				skip_q <= 1'b0;
				status_q.skip <= 1'b0;
				status_q.cycles <= 2'h1;
			end
			if ((state_q == CSD_ST_FLUSH) & q4_end) begin
				status_q.cycles <= status_q.cycles + 2'h1;
			end
			if (state_q == CSD_ST_EXEC) begin
				unique case (phase_q)
					CSD_Q1: begin
						// Decode and address formation.
						if (instr_q[15:9] == CSD_OPC_GREATER) begin
							op_q <= CSD_OP_GREATER;
						end else if (instr_q[15:9] == CSD_OPC_LESS) begin
							op_q <= CSD_OP_LESS;
						end else if (instr_q == CSD_OPC_DECIMAL) begin
							op_q <= CSD_OP_DECIMAL;
						end else begin
							op_q <= CSD_OP_NONE;
						end
						// An opcode outside the three still spends four quarters,
						// so software sees one timing and only this flag differs.
						status_q.unknown_op <= (instr_q[15:9] != CSD_OPC_GREATER) &
							(instr_q[15:9] != CSD_OPC_LESS) &
							(instr_q != CSD_OPC_DECIMAL);
						status_q.indexed <= 1'b0;
						if (instr_q[CSD_OP_BANK_BIT]) begin
							addr_q <= {bank_select_register_q, instr_q[7:0]};
						end else if (ext_q & (instr_q[15:9] == CSD_OPC_GREATER) &
							(instr_q[7:0] <= CSD_INDEXED_MAX)) begin
							addr_q <= index_q + {4'h0, instr_q[7:0]};
							status_q.indexed <= 1'b1;
						end else if (instr_q[7:0] < CSD_ACCESS_SPLIT) begin
							addr_q <= {4'h0, instr_q[7:0]};
						end else begin
							addr_q <= {CSD_ACCESS_HIGH_BANK, instr_q[7:0]};
						end
					end
					CSD_Q2: begin
						// The file byte is taken in the second quarter.
						operand_q <= data_q;
					end
					CSD_Q3: begin
						unique case (op_q)
							CSD_OP_GREATER: begin
								skip_q <= ~diff[8] & (diff[7:0] != 8'h00);
								status_q.skip <= ~diff[8] & (diff[7:0] != 8'h00);
							end
							CSD_OP_LESS: begin
								skip_q <= diff[8];
								status_q.skip <= diff[8];
							end
							default: skip_q <= 1'b0;
						endcase
					end
					CSD_Q4: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Working register and flags. Only decimal adjust writes the working register and carry from
	// the sequencer; compares leave every flag alone.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			working_register_q <= CSD_RST_BYTE;
			carry_q <= 1'b0;
			digit_carry_flag_q <= 1'b0;
		end else if ((state_q == CSD_ST_EXEC) & q4_end &
			(op_q == CSD_OP_DECIMAL)) begin
			working_register_q <= adjusted;
			carry_q <= adjust_carry;
		end else if (bus_take & req.write & (state_q == CSD_ST_IDLE)) begin
			if (req.address == CSD_OFF_WORK) begin
				working_register_q <= req.writedata[7:0];
			end
			if (req.address == CSD_OFF_FLAGS) begin
				carry_q <= req.writedata[CSD_FLAG_CARRY];
				digit_carry_flag_q <= req.writedata[CSD_FLAG_DIGIT];
			end
		end
	end

endmodule : csd_core

`default_nettype wire

// ### dv/csd_core_sva.sv
`timescale 1ns/1ps
`default_nettype none

module csd_core_sva (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Bus and fetch control.
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic cancel_fetch
);
	import csd_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// A start counts only at the edge where the bus completes it.
	wire go = avs_write && !avs_waitrequest &&
		avs_address == CSD_OFF_CTRL && avs_writedata[CSD_CTRL_GO];

	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_answer_a: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest)
		else $error("bus request not answered");
	reset_idle_a: assert property (disable iff (1'b0) sys_rst |=>
		avs_waitrequest && !cancel_fetch && avs_readdata == 32'h0)
		else $error("outputs not idle under reset");
	cancel_len_a: assert property ($rose(cancel_fetch) |->
		cancel_fetch [*4] ##1 (!cancel_fetch or
		cancel_fetch [*4] ##1 !cancel_fetch))
		else $error("cancel window has wrong length");
	quiet_quarters_a: assert property (go |=> !cancel_fetch [*4])
		else $error("cancel raised inside the compare cycle");
	cancel_origin_a: assert property ($rose(cancel_fetch) |->
		$past(go, 5)) else $error("cancel without a finished start");
	read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved without a read");
	read_zero_a: assert property (avs_read && !avs_waitrequest &&
		(avs_address == CSD_OFF_CTRL || avs_address > CSD_OFF_ADDR) |->
		avs_readdata[0] == 1'b0 &&
		(avs_address == CSD_OFF_CTRL || avs_readdata == 32'h0))
		else $error("go bit or unmapped place read nonzero");

	cover property ($rose(cancel_fetch));
	cover property (cancel_fetch [*5]);
	cover property (go);
endmodule : csd_core_sva

////////////////////////////////////////////////
bind csd_core csd_core_sva u_sva (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.cancel_fetch(cancel_fetch)
);

`default_nettype wire

// ### dv/csd_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module csd_core_tb_top;
	import csd_pkg::*;
	logic sys_clk, sys_rst, avs_read, avs_write;
	logic avs_waitrequest, cancel_fetch, g, a, sk, ix_m;
	logic [5:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [63:0] q[$];
	logic [63:0] nt;
	logic [7:0] f, d, w;
	logic [3:0] bk;
	logic [11:0] ix, ad;
	logic [2:0] ct;
	logic [1:0] fl;
	logic [9:0] e;
	int n_fail, num_checks, cyc, i;
	int nc, nc0;

	csd_core u_dut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.cancel_fetch(cancel_fetch)
	);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			summarize();
		end
	end

	// Counts the edges at which the fetch is held cancelled.
	always @(posedge sys_clk) begin
		if (cancel_fetch === 1'b1) nc++;
	end

	// Every read leaves a note; a zero mask marks a poll that is not judged.
	always @(posedge sys_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			nt = q.pop_front();
			if (nt[31:0] != 32'h0) begin
				num_checks++;
				if ((avs_readdata & nt[31:0]) !== (nt[63:32] & nt[31:0])) begin
					n_fail++;
					$display("wrong value reg_%h exp %h got %h", avs_address,
						nt[63:32], avs_readdata);
				end
			end
		end
	end

	////////////////////////////////////////////////
	task automatic bus(input logic wr, input logic [5:0] at,
		input logic [31:0] dat, input logic [31:0] m);
		if (!wr) q.push_back({dat, m});
		avs_address <= at;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= dat;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic run(input logic [15:0] ins, input logic [2:0] c);
		bus(1'b1, CSD_OFF_INSTR, {16'h0, ins}, 32'h0);
		bus(1'b1, CSD_OFF_WORK, {24'h0, w}, 32'h0);
		bus(1'b1, CSD_OFF_DATA, {24'h0, d}, 32'h0);
		bus(1'b1, CSD_OFF_FLAGS, {30'h0, fl}, 32'h0);
		bus(1'b1, CSD_OFF_CTRL, {29'h0, c[2:1], 1'b1}, 32'h0);
		// Lands while busy, so the block must drop it.
		bus(1'b1, CSD_OFF_WORK, {24'h0, ~w}, 32'h0);
		rd = 32'h1;
		while (rd[0] !== 1'b0) bus(1'b0, CSD_OFF_STATUS, 32'h0, 32'h0);
	endtask : run

	initial begin
		sys_rst = 1'b1;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		n_fail = 0;
		num_checks = 0;
		cyc = 0;
		void'($urandom(32'h4D26));
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 16; i++) bus(1'b0, 6'(i * 4), 32'h0, 32'hFFFFFFFF);
		for (i = 0; i < 60; i++) begin
			g = $urandom;
			a = $urandom;
			f = $urandom;
			d = $urandom;
			w = (i % 4 == 0) ? d : $urandom;
			bk = $urandom;
			ix = $urandom;
			ct = $urandom;
			fl = $urandom;
			bus(1'b1, CSD_OFF_BANK, {28'h0, bk}, 32'h0);
			bus(1'b1, CSD_OFF_INDEX, {20'h0, ix}, 32'h0);
			nc0 = nc;
			run({g ? CSD_OPC_GREATER : CSD_OPC_LESS, a, f}, ct);
			sk = g ? d > w : d < w;
			ix_m = !a && ct[2] && g && !(f > CSD_INDEXED_MAX);
			ad = a ? {bk, f} : ix_m ? ix + 12'(f) :
				{(f < CSD_ACCESS_SPLIT) ? 4'h0 : CSD_ACCESS_HIGH_BANK, f};
			bus(1'b0, CSD_OFF_STATUS, {26'h0, sk ? (ct[1] ? 2'h3 : 2'h2) : 2'h1,
				1'b0, ix_m, sk, 1'b0}, 32'h3F);
			bus(1'b0, CSD_OFF_ADDR, {20'h0, ad}, 32'hFFF);
			bus(1'b0, CSD_OFF_WORK, {24'h0, w}, 32'hFF);
			bus(1'b0, CSD_OFF_FLAGS, {30'h0, fl}, 32'h3);
			num_checks++;
			if (nc - nc0 != (sk ? (ct[1] ? 8 : 4) : 0)) begin
				n_fail++;
				$display("wrong value cancel_fetch exp %0d got %0d",
					sk ? (ct[1] ? 8 : 4) : 0, nc - nc0);
			end
		end
		for (i = 0; i < 40; i++) begin
			w = (i == 0) ? 8'hA5 : $urandom;
			fl = (i == 0) ? 2'h0 : $urandom;
			d = $urandom;
			run(CSD_OPC_DECIMAL, 3'h0);
			e[3:0] = (w[3:0] > 4'h9 || fl[1]) ? w[3:0] + 4'h6 : w[3:0];
			{e[8], e[7:4]} = {1'b0, w[7:4]} + 5'(fl[1]);
			if ({e[8], e[7:4]} > 5'h09 || fl[0])
				{e[8], e[7:4]} = {e[8], e[7:4]} + 5'h06;
			bus(1'b0, CSD_OFF_WORK, {24'h0, e[7:0]}, 32'hFF);
			bus(1'b0, CSD_OFF_FLAGS, {30'h0, fl[1], fl[0] | e[8]},
				32'h3);
		end
		w = 8'h3C;
		run(16'h6200, 3'h0);
		bus(1'b0, CSD_OFF_STATUS, 32'h8, 32'hE);
		bus(1'b0, CSD_OFF_WORK, {24'h0, w}, 32'hFF);
		summarize();
	end
endmodule : csd_core_tb_top

`default_nettype wire
